// file: src/pmseq_pkg.sv
// Package with constants and carrier types for the power mode sequencer.
package pmseq_pkg;

  // Number of consecutive agreeing samples before a comparator level is accepted.
  localparam int unsigned PMSEQ_FILT_CYCLES = 4;
  localparam logic [2:0] PMSEQ_FILT_MAX = 3'h3;
  localparam logic [2:0] PMSEQ_FILT_RST = 3'h0;

  // Mode states, one-hot.
  typedef enum logic [2:0]
  {
    PMSEQ_SHUTDOWN = 3'h1,
    PMSEQ_STANDBY = 3'h2,
    PMSEQ_OPERATE = 3'h4
  } pmseq_mode_e;

  // Raw comparator outcomes, each high when its level is cleared.
  typedef struct packed
  {
    logic input_supply_ok;   // Input above input_supply_low_limit.
    logic en_stby_rise;      // Enable input above standby_level, rising comparator.
    logic en_stby_fall;      // Enable input above standby_level minus hysteresis.
    logic en_oper;           // Enable input above operating_level.
    logic high_rail_rise;    // High rail above its rising limit.
    logic high_rail_fall;    // High rail above its falling limit.
    logic mid_rail_rise;     // Mid rail above its rising limit.
    logic core_rail_rise;    // Core rail above its rising limit.
  } pmseq_cmp_s;

  localparam int unsigned PMSEQ_NCMP = 8;
  localparam logic [7:0] PMSEQ_CMP_RST = 8'h00;

endpackage : pmseq_pkg

// file: src/pmseq_top.sv
// Power mode sequencer: filters comparators, picks the mode, drives rails and processor reset.
`timescale 1ns/1ps
// How it works
// - Start only with both undervoltage levels cleared.
// - Below standby level minus hysteresis hold shutdown, everything off.
// - Between levels enable rails, processor stays off.
// - Operate needs operating level and all rails up.
// - Processor reset held until all rails rise.
// - High rail below falling limit forces hard reset.
// - Shutdown/standby uses separate rising and falling levels.
module pmseq_top
  import pmseq_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire pmseq_cmp_s cmp_i,
  output logic high_rail_regulator_en_o,
  output logic mid_rail_regulator_en_o,
  output logic core_rail_regulator_en_o,
  output logic embedded_processor_rst_o,
  output logic hard_reset_o,
  output logic [2:0] mode_o
);

  // Debounce step: move the count toward the new sample and flip only at the end.
  function automatic logic [3:0] filt_step(input logic smp, input logic cur,
                                           input logic [2:0] cnt);
    logic [3:0] res;
    res = {cur, cnt};
    if (smp == cur)
      res = {cur, PMSEQ_FILT_RST};
    else if (cnt == PMSEQ_FILT_MAX)
      res = {smp, PMSEQ_FILT_RST};
    else
      res = {cur, cnt + 3'h1};
    return res;
  endfunction : filt_step

  // Regulator enable decode, shared by the three rail enables.
  // All three rails switch together, since the high rail feeds the other two anyway.
  function automatic logic rails_on(input pmseq_mode_e mode);
    return (mode != PMSEQ_SHUTDOWN);
  endfunction : rails_on

  logic [PMSEQ_NCMP-1:0] sync1_r;
  logic [PMSEQ_NCMP-1:0] sync2_r;
  logic [PMSEQ_NCMP-1:0] filt_r;
  logic [2:0] cnt_r [PMSEQ_NCMP];
  pmseq_cmp_s f;
  pmseq_mode_e mode_r;
  pmseq_mode_e mode_nxt;
  logic rails_up;
  logic startup_ok;

  // Two-flop synchroniser; the first stage feeds only the second.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sync1_r <= PMSEQ_CMP_RST;
      sync2_r <= PMSEQ_CMP_RST;
    end
    else
    begin
      sync1_r <= cmp_i;
      sync2_r <= sync1_r;
    end
  end

  // Glitch filter: a level must persist for several samples before it counts.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      filt_r <= PMSEQ_CMP_RST;
      for (int i = 0; i < PMSEQ_NCMP; i++)
        cnt_r[i] <= PMSEQ_FILT_RST;
    end
    else
    begin
      for (int i = 0; i < PMSEQ_NCMP; i++)
      begin
        {filt_r[i], cnt_r[i]} <= filt_step(sync2_r[i], filt_r[i], cnt_r[i]);
      end
    end
  end

  assign f = pmseq_cmp_s'(filt_r);
  assign rails_up = f.high_rail_rise && f.mid_rail_rise && f.core_rail_rise;
  assign startup_ok = f.input_supply_ok;

  // Mode selection. Standby is entered on the rising comparator and left for shutdown only on the
  // falling one or on input supply loss, so noise near the standby level cannot chatter the rails.
  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      PMSEQ_SHUTDOWN:
        if (startup_ok && f.en_stby_rise)
          mode_nxt = PMSEQ_STANDBY;
      PMSEQ_STANDBY:
        if (!startup_ok || !f.en_stby_fall)
          mode_nxt = PMSEQ_SHUTDOWN;
        else if (f.en_oper && rails_up)
          mode_nxt = PMSEQ_OPERATE;
      PMSEQ_OPERATE:
        if (!startup_ok || !f.en_stby_fall)
          mode_nxt = PMSEQ_SHUTDOWN;
        else if (!f.en_oper || !f.high_rail_fall)
          mode_nxt = PMSEQ_STANDBY;
      default:
        mode_nxt = PMSEQ_SHUTDOWN;
    endcase
  end

  // Mode register.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      mode_r <= PMSEQ_SHUTDOWN;
    else
      mode_r <= mode_nxt;
  end

  // Rail enables follow the next mode, so they change on the same edge as mode_o.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      high_rail_regulator_en_o <= 1'b0;
      mid_rail_regulator_en_o <= 1'b0;
      core_rail_regulator_en_o <= 1'b0;
    end
    else
    begin
      high_rail_regulator_en_o <= rails_on(mode_nxt);
      mid_rail_regulator_en_o <= rails_on(mode_nxt);
      core_rail_regulator_en_o <= rails_on(mode_nxt);
    end
  end

  // Processor reset is released only on entry to operate. Operate is not left when only
  // the mid or core rail sags, because only the high rail has a falling comparator.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      embedded_processor_rst_o <= 1'b1;
    else
      embedded_processor_rst_o <= (mode_nxt != PMSEQ_OPERATE);
  end

  // Hard reset tracks the filtered high rail falling comparator. It starts asserted, so
  // the device stays in hard reset until the high rail has been seen good after reset.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      hard_reset_o <= 1'b1;
    else
      hard_reset_o <= !f.high_rail_fall;
  end

  // Mode output mirrors the mode register, taken from the next mode to stay in step.
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      mode_o <= PMSEQ_SHUTDOWN;
    else
      mode_o <= mode_nxt;
  end

  // All checks share the system clock and are idle while reset is applied.
  default clocking cb_main @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  // Output checks against the mode that is shown, plus agreement of the three rail enables.
  a_shutdown_rails_off: assert property (
    (mode_o == PMSEQ_SHUTDOWN) |-> !high_rail_regulator_en_o && !core_rail_regulator_en_o)
    else $error("Rails on in shutdown.");
  a_standby_cpu_held: assert property (
    (mode_o == PMSEQ_STANDBY) |-> embedded_processor_rst_o && mid_rail_regulator_en_o)
    else $error("Standby state outputs wrong.");
  a_rails_together: assert property (
    (high_rail_regulator_en_o == mid_rail_regulator_en_o)
    && (mid_rail_regulator_en_o == core_rail_regulator_en_o))
    else $error("Rail enables disagree.");
  a_operate_cpu_run: assert property (
    (mode_o == PMSEQ_OPERATE) |-> !embedded_processor_rst_o)
    else $error("Processor held in operate.");

  // Transition checks; each compares the filtered levels with the outputs one cycle later.
  a_operate_needs_all: assert property (
    $rose(mode_o == PMSEQ_OPERATE) |-> $past(f.en_oper && rails_up))
    else $error("Operate entered without conditions.");
  a_cpu_rst_rails: assert property (
    !$past(rails_up) |-> embedded_processor_rst_o)
    else $error("Processor released before rails up.");
  a_hard_reset: assert property (
    !f.high_rail_fall |=> hard_reset_o)
    else $error("No hard reset on high rail low.");
  a_start_gate: assert property (
    (mode_o == PMSEQ_SHUTDOWN && !(startup_ok && f.en_stby_rise)) |=> mode_o == PMSEQ_SHUTDOWN)
    else $error("Left shutdown without start conditions.");
  a_supply_loss: assert property (
    !startup_ok |=> mode_o == PMSEQ_SHUTDOWN)
    else $error("Mode kept with input supply low.");
  a_hysteresis: assert property (
    (mode_o == PMSEQ_STANDBY && startup_ok && f.en_stby_fall) |=> mode_o != PMSEQ_SHUTDOWN)
    else $error("Standby left above falling level.");

  // Filter check on one lane; all lanes share the same step function.
  a_glitch_filter: assert property (
    $changed(filt_r[0]) |-> $past(sync2_r[0], 4) == filt_r[0])
    else $error("Filter passed a short pulse.");

  // Main scenarios that the bench is expected to reach.
  c_reach_standby: cover property (mode_o == PMSEQ_STANDBY);
  c_reach_operate: cover property (mode_o == PMSEQ_OPERATE);
  c_operate_drop: cover property (mode_o == PMSEQ_OPERATE ##1 mode_o == PMSEQ_STANDBY);
  c_hard_reset_gone: cover property ($fell(hard_reset_o));
  c_back_to_off: cover property (mode_o == PMSEQ_STANDBY ##1 mode_o == PMSEQ_SHUTDOWN);

endmodule : pmseq_top

// file: tb/pmseq_cmp_model.sv
// Behavioural model of the supply comparators and the enable pin divider.
`timescale 1ns/1ps
module pmseq_cmp_model
  import pmseq_pkg::*;
(
  input wire logic [1:0] en_lvl_i,
  input wire logic supply_ok_i,
  input wire logic rails_up_i,
  input wire logic high_ok_i,
  input wire logic reg_en_i,
  output pmseq_cmp_s cmp_o
);
  // Enable level 0 is low, 1 is the hysteresis band, 2 is standby, 3 is operating.
  // A rail can only read good while its regulator is enabled.
  always_comb
  begin
    cmp_o.input_supply_ok = supply_ok_i;
    cmp_o.en_stby_rise = (en_lvl_i >= 2'h2);
    cmp_o.en_stby_fall = (en_lvl_i >= 2'h1);
    cmp_o.en_oper = (en_lvl_i == 2'h3);
    cmp_o.high_rail_rise = rails_up_i & high_ok_i & reg_en_i; // Below falling is below rising.
    cmp_o.high_rail_fall = high_ok_i & reg_en_i;
    cmp_o.mid_rail_rise = rails_up_i & reg_en_i;
    cmp_o.core_rail_rise = rails_up_i & reg_en_i;
  end
endmodule : pmseq_cmp_model

// file: tb/test_pmseq_top.sv
// Testbench for the power mode sequencer.
`timescale 1ns/1ps
module test_pmseq_top;
  import pmseq_pkg::*;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] en_lvl = 2'h0;
  logic sup = 1'b0;
  logic up = 1'b0;
  logic hok = 1'b0;
  pmseq_cmp_s cmp;
  logic hi, mid, core, cpu_rst, hard;
  logic [2:0] mode;
  logic [7:0] outs;
  int n_mismatch = 0;
  int tests_run = 0;

  // Clock at 50 MHz.
  always #10 clock_i = ~clock_i;

  pmseq_cmp_model u_pmseq_cmp_model (.en_lvl_i(en_lvl), .supply_ok_i(sup), .rails_up_i(up),
    .high_ok_i(hok), .reg_en_i(hi), .cmp_o(cmp));
  pmseq_top u_pmseq_top (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cmp_i(cmp),
    .high_rail_regulator_en_o(hi), .mid_rail_regulator_en_o(mid),
    .core_rail_regulator_en_o(core), .embedded_processor_rst_o(cpu_rst),
    .hard_reset_o(hard), .mode_o(mode));

  // Output vector: rail enables, processor reset, hard reset, mode.
  assign outs = {hi, mid, core, cpu_rst, hard, mode};

  // Compares a seen value with its expectation and counts a mismatch.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
  begin
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: outputs %h, expected %h", $time, seen, exp);
    end
  end
  endtask : chk

  // Applies comparator levels, then waits past two chained filter latencies: a rail
  // only reads good after its registered enable has gone through the filter too.
  task automatic step(input logic [1:0] e, input logic s, input logic u, input logic h);
  begin
    @(negedge clock_i);
    en_lvl = e;
    sup = s;
    up = u;
    hok = h;
    repeat (20) @(negedge clock_i);
  end
  endtask : step

  // Input supply low blocks start even with the enable input high.
  task automatic sc_supply_low;
  begin
    step(2'h3, 1'b0, 1'b1, 1'b1);
    chk(outs, 8'h19);
  end
  endtask : sc_supply_low

  // The hysteresis band alone does not start the device from shutdown.
  task automatic sc_band_from_off;
  begin
    step(2'h1, 1'b1, 1'b1, 1'b1);
    chk(outs, 8'h19);
  end
  endtask : sc_band_from_off

  // Standby: rails on, processor held, hard reset gone once the high rail is good.
  task automatic sc_standby;
  begin
    step(2'h2, 1'b1, 1'b1, 1'b1);
    chk(outs, 8'hF2);
  end
  endtask : sc_standby

  // Operating level without the rails up keeps the processor in reset.
  task automatic sc_rails_pending;
  begin
    step(2'h3, 1'b1, 1'b0, 1'b1);
    chk(outs, 8'hF2);
  end
  endtask : sc_rails_pending

  // Operating level with all rails up releases the processor.
  task automatic sc_operate;
  begin
    step(2'h3, 1'b1, 1'b1, 1'b1);
    chk(outs, 8'hE4);
  end
  endtask : sc_operate

  // A two cycle dip of the enable input must not leave operating mode.
  task automatic sc_glitch;
  begin
    @(negedge clock_i);
    en_lvl = 2'h2;
    repeat (2) @(negedge clock_i);
    en_lvl = 2'h3;
    repeat (20) @(negedge clock_i);
    chk(outs, 8'hE4);
  end
  endtask : sc_glitch

  // High rail below its falling limit drops to standby under hard reset.
  task automatic sc_high_rail_loss;
  begin
    step(2'h3, 1'b1, 1'b1, 1'b0);
    chk(outs, 8'hFA);
  end
  endtask : sc_high_rail_loss

  // Inside the hysteresis band the device stays in standby.
  task automatic sc_band_from_on;
  begin
    step(2'h1, 1'b1, 1'b1, 1'b1);
    chk(outs, 8'hF2);
  end
  endtask : sc_band_from_on

  // Below the standby level minus hysteresis everything is off again.
  task automatic sc_off;
  begin
    step(2'h0, 1'b1, 1'b1, 1'b1);
    chk(outs, 8'h19);
  end
  endtask : sc_off

  task automatic finish_test;
  begin
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask : finish_test

  // Main sequence; each step is judged before the next one starts.
  initial
  begin
    repeat (12) @(negedge clock_i);
    sys_rst_i = 1'b0;
    sc_supply_low();
    sc_band_from_off();
    sc_standby();
    sc_rails_pending();
    sc_operate();
    sc_glitch();
    sc_high_rail_loss();
    sc_band_from_on();
    sc_off();
    finish_test();
  end
endmodule : test_pmseq_top
